// ===== inc/pfds_pkg.sv
// Package: offsets, field layout, reset values and function codes of the pin mux
package pfds_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // Register byte offsets
  localparam logic [23:0] SPR_OFS = 24'h10004a;
  localparam logic [23:0] TPR_OFS = 24'h10004c;
  localparam logic [23:0] CPR_OFS = 24'h10004e;
  localparam logic [23:0] BDS_OFS = 24'h100050;
  localparam logic [23:0] CDS_OFS = 24'h100051;

  // Field positions
  localparam int SEL1_LSB     = 6;
  localparam int SEL0_BIT     = 5;
  localparam int DIN_LSB      = 3;
  localparam int DOUT_BIT     = 2;
  localparam int SCK_LSB      = 0;
  localparam int TIN_LSB      = 8;
  localparam int TOUT_LSB     = 0;
  localparam int TBCLK_BIT    = 2;
  localparam int UDIS_BIT     = 1;
  localparam int LDIS_BIT     = 0;
  localparam int BUS_MAIN_BIT = 4;
  localparam int BUS_HS_BIT   = 0;

  // Reset values and implemented-bit masks
  localparam logic [7:0]  SPR_RST  = 8'h00;
  localparam logic [15:0] TPR_RST  = 16'h0000;
  localparam logic [7:0]  CPR_RST  = 8'h00;
  localparam logic [7:0]  CPR_MASK = 8'h07;
  localparam logic [7:0]  BDS_MASK = 8'h11;
  localparam logic [7:0]  CDS_MASK = 8'h55;

  // Which timer pins own a meaningful code 01
  localparam logic [3:0] TIN_ALT_A  = 4'he;
  localparam logic [3:0] TOUT_ALT_A = 4'h8;

  // Normalised pin function codes
  localparam logic [1:0] FN_GPIO  = 2'h0;
  localparam logic [1:0] FN_ALT_A = 2'h1;
  localparam logic [1:0] FN_ALT_B = 2'h2;
  localparam logic [1:0] FN_PRIM  = 2'h3;

  // Code 01 falls back to GPIO where the pin has no such alternate
  function automatic logic [1:0] pfds_norm(input logic [1:0] code, input logic alt_a);
    pfds_norm = (code == FN_ALT_A && !alt_a) ? FN_GPIO : code;
  endfunction

  // Four packed two-bit fields at once
  function automatic logic [7:0] pfds_norm4(input logic [7:0] f, input logic [3:0] alt_a);
    pfds_norm4 = {pfds_norm(f[7:6], alt_a[3]), pfds_norm(f[5:4], alt_a[2]),
                  pfds_norm(f[3:2], alt_a[1]), pfds_norm(f[1:0], alt_a[0])};
  endfunction
endpackage

// ===== src/pfds_pin_mux.sv
// Pin function routing and drive strength configuration registers
//
// Design decision made here: the address-and-strobe port.

// Summary of operation
// - Select1 pin: 0x GPIO, 10 sdram enable, 11 select1
// - Select0 pin: bit 5 GPIO or select0
// - Data-in pin: 0x GPIO, 10 two-wire data, 11 data-in
// - Data-out pin: bit 2 GPIO or data-out
// - Clock pin: 0x GPIO, 10 two-wire clock, 11 clock
// - Timer inputs 3..0 fields in bits 15..8
// - Timer input codes 10 give alternates, 01 on inputs 3..1 only
// - Timer outputs 3..0 fields in bits 7..0
// - Timer output codes 10 give alternates, 01 on output 3 only
// - Coproc bit 2 routes time-base clock pin
// - Coproc bit 1 routes upper output disable
// - Coproc bit 0 routes lower output disable
// - Drive registers read back implemented bits of last written value
// - Bus drive bit 4 sets main bus pins
// - Bus drive bit 0 sets handshake pins
// - Drive bits reset from strap pins
// - Channel drive bits 6,4,2,0 set groups
// - Routed pins default to GPIO after reset
module pfds_pin_mux
  import pfds_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [DATA_W-1:0] rd_data,
  // Reset configuration straps
  input  wire logic              reset_config_pin,
  input  wire logic              strap_data21,
  // Serial peripheral pin functions
  output logic      [1:0]        select1_route_field,
  output logic                   select0_route_bit,
  output logic      [1:0]        data_in_route_field,
  output logic                   data_out_route_bit,
  output logic      [1:0]        serial_clock_route_field,
  // Timer pin functions, pin 3 in the top pair
  output logic      [7:0]        timer_input_fn,
  output logic      [7:0]        timer_output_fn,
  // Coprocessor pin functions
  output logic                   time_base_clock_pin_fn,
  output logic                   upper_channel_output_disable_fn,
  output logic                   lower_channel_output_disable_fn,
  // Drive strengths, 1 = high drive
  output logic                   bus_main_drive_bit,
  output logic                   bus_handshake_drive_bit,
  output logic      [3:0]        channel_drive_bits
);

  logic [7:0]        spr_reg;
  logic [15:0]       tpr_reg;
  logic [7:0]        cpr_reg;
  logic [7:0]        bds_reg;
  logic [7:0]        cds_reg;
  logic [7:0]        spr_next;
  logic [15:0]       tpr_next;
  logic [7:0]        cpr_next;
  logic [7:0]        bds_next;
  logic [7:0]        cds_next;
  logic [1:0]        sel1_fn_reg;
  logic [1:0]        din_fn_reg;
  logic [1:0]        sck_fn_reg;
  logic [7:0]        tin_fn_reg;
  logic [7:0]        tout_fn_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic [2:0]        rcfg_sync_reg;
  logic [2:0]        d21_sync_reg;
  logic              rcfg_ok_reg;
  logic              d21_ok_reg;

  // Address decode
  wire hit_spr = (addr == SPR_OFS);
  wire hit_tpr = (addr == TPR_OFS);
  wire hit_cpr = (addr == CPR_OFS);
  wire hit_bds = (addr == BDS_OFS);
  wire hit_cds = (addr == CDS_OFS);

  // Straps: three stages, a change counts once the last two agree
  always_ff @(posedge sys_clk) begin
    rcfg_sync_reg <= {rcfg_sync_reg[1:0], reset_config_pin};
    d21_sync_reg  <= {d21_sync_reg[1:0], strap_data21};
    if (rcfg_sync_reg[2] == rcfg_sync_reg[1]) begin
      rcfg_ok_reg <= rcfg_sync_reg[2];
    end
    if (d21_sync_reg[2] == d21_sync_reg[1]) begin
      d21_ok_reg <= d21_sync_reg[2];
    end
  end

  // Strapped drive level: config high forces low drive
  wire       strap_level = !rcfg_ok_reg && d21_ok_reg;
  wire [7:0] strap_fill  = {8{strap_level}};

  // Next values; reserved bits never store
  assign spr_next = (wr_stb && hit_spr) ? wr_data[7:0] : spr_reg;
  assign tpr_next = (wr_stb && hit_tpr) ? wr_data : tpr_reg;
  assign cpr_next = (wr_stb && hit_cpr) ? (wr_data[7:0] & CPR_MASK) : cpr_reg;
  assign bds_next = (wr_stb && hit_bds) ? (wr_data[7:0] & BDS_MASK) : bds_reg;
  assign cds_next = (wr_stb && hit_cds) ? (wr_data[7:0] & CDS_MASK) : cds_reg;

  // Readback; unmapped addresses return zero
  wire [DATA_W-1:0] rd_mux =
    hit_spr ? {8'h00, spr_reg} :
    hit_tpr ? tpr_reg :
    hit_cpr ? {8'h00, cpr_reg} :
    hit_bds ? {8'h00, bds_reg} :
    hit_cds ? {8'h00, cds_reg} : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spr_reg <= SPR_RST;
      tpr_reg <= TPR_RST;
      cpr_reg <= CPR_RST;
      bds_reg <= strap_fill & BDS_MASK;
      cds_reg <= strap_fill & CDS_MASK;
    end else begin
      spr_reg <= spr_next;
      tpr_reg <= tpr_next;
      cpr_reg <= cpr_next;
      bds_reg <= bds_next;
      cds_reg <= cds_next;
    end
  end

  // Decoded functions follow the write on the same edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel1_fn_reg <= FN_GPIO;
      din_fn_reg  <= FN_GPIO;
      sck_fn_reg  <= FN_GPIO;
      tin_fn_reg  <= 8'h00;
      tout_fn_reg <= 8'h00;
    end else begin
      sel1_fn_reg <= pfds_norm(spr_next[SEL1_LSB+:2], 1'b0);
      din_fn_reg  <= pfds_norm(spr_next[DIN_LSB+:2], 1'b0);
      sck_fn_reg  <= pfds_norm(spr_next[SCK_LSB+:2], 1'b0);
      tin_fn_reg  <= pfds_norm4(tpr_next[TIN_LSB+:8], TIN_ALT_A);
      tout_fn_reg <= pfds_norm4(tpr_next[TOUT_LSB+:8], TOUT_ALT_A);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_reg <= 16'h0000;
    end else begin
      rd_data_reg <= rd_stb ? rd_mux : 16'h0000;
    end
  end

  // Static levels to the pads, all straight from flops
  assign rd_data                         = rd_data_reg;
  assign select1_route_field             = sel1_fn_reg;
  assign select0_route_bit               = spr_reg[SEL0_BIT];
  assign data_in_route_field             = din_fn_reg;
  assign data_out_route_bit              = spr_reg[DOUT_BIT];
  assign serial_clock_route_field        = sck_fn_reg;
  assign timer_input_fn                  = tin_fn_reg;
  assign timer_output_fn                 = tout_fn_reg;
  assign time_base_clock_pin_fn          = cpr_reg[TBCLK_BIT];
  assign upper_channel_output_disable_fn = cpr_reg[UDIS_BIT];
  assign lower_channel_output_disable_fn = cpr_reg[LDIS_BIT];
  assign bus_main_drive_bit              = bds_reg[BUS_MAIN_BIT];
  assign bus_handshake_drive_bit         = bds_reg[BUS_HS_BIT];
  assign channel_drive_bits              = {cds_reg[6], cds_reg[4], cds_reg[2], cds_reg[0]};

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_sel1_route: assert property (
    wr_stb && hit_spr |=> select1_route_field ==
      ($past(wr_data[7]) ? $past(wr_data[7:6]) : FN_GPIO))
    else $error("select1 route wrong");

  a_sel0_route: assert property (
    wr_stb && hit_spr |=> select0_route_bit == $past(wr_data[5]))
    else $error("select0 route wrong");

  a_din_route: assert property (
    wr_stb && hit_spr |=> data_in_route_field ==
      ($past(wr_data[4]) ? $past(wr_data[4:3]) : FN_GPIO))
    else $error("data-in route wrong");

  a_dout_sck_route: assert property (
    wr_stb && hit_spr |=> data_out_route_bit == $past(wr_data[2]) &&
      serial_clock_route_field == ($past(wr_data[1]) ? $past(wr_data[1:0]) : FN_GPIO))
    else $error("data-out or clock route wrong");

  a_tin_alt_codes: assert property (
    wr_stb && hit_tpr && wr_data[15:8] == 8'h55 |=> timer_input_fn == 8'h54)
    else $error("timer input code 01 wrong");

  a_tout_alt_codes: assert property (
    wr_stb && hit_tpr && wr_data[7:0] == 8'h55 |=> timer_output_fn == 8'h40)
    else $error("timer output code 01 wrong");

  a_timer_prim_b: assert property (
    wr_stb && hit_tpr && wr_data == 16'hae27 |=>
      timer_input_fn == 8'hae && timer_output_fn == 8'h23)
    else $error("timer codes 10 or 11 wrong");

  a_coproc_route: assert property (
    wr_stb && hit_cpr |=> {time_base_clock_pin_fn, upper_channel_output_disable_fn,
      lower_channel_output_disable_fn} == $past(wr_data[2:0]))
    else $error("coprocessor route wrong");

  a_drive_readback: assert property (
    wr_stb && hit_bds ##1 rd_stb && hit_bds && !wr_stb |=>
      rd_data == {8'h00, $past(wr_data[7:0], 2) & BDS_MASK})
    else $error("bus drive readback wrong");

  a_chan_drive: assert property (
    wr_stb && hit_cds |=> channel_drive_bits ==
      {$past(wr_data[6]), $past(wr_data[4]), $past(wr_data[2]), $past(wr_data[0])})
    else $error("channel drive wrong");

  a_strap_reset: assert property (
    $fell(rst) |-> bus_main_drive_bit == $past(strap_level) &&
      channel_drive_bits == {4{$past(strap_level)}})
    else $error("strap reset drive wrong");

  a_route_default: assert property (
    $fell(rst) |-> timer_input_fn == 8'h00 && select1_route_field == FN_GPIO &&
      !time_base_clock_pin_fn)
    else $error("route not GPIO after reset");

  a_resv_zero: assert property (
    rd_stb && hit_cpr |=> rd_data[15:3] == 13'h0000)
    else $error("reserved bits read nonzero");

  a_unmapped_zero: assert property (
    rd_stb && !(hit_spr || hit_tpr || hit_cpr || hit_bds || hit_cds) |=> rd_data == 16'h0000)
    else $error("unmapped read nonzero");

  // Read data must not linger past its one cycle
  a_rd_one_cycle: assert property (
    !rd_stb |=> rd_data == 16'h0000)
    else $error("read data stands too long");

  // Back-to-back write and read return what was just stored
  a_spr_readback: assert property (
    wr_stb && hit_spr ##1 rd_stb && hit_spr && !wr_stb |=>
      rd_data == {8'h00, $past(wr_data[7:0], 2)})
    else $error("serial route readback wrong");

  a_tpr_readback: assert property (
    wr_stb && hit_tpr ##1 rd_stb && hit_tpr && !wr_stb |=>
      rd_data == $past(wr_data, 2))
    else $error("timer route readback wrong");

  a_cpr_readback: assert property (
    wr_stb && hit_cpr ##1 rd_stb && hit_cpr && !wr_stb |=>
      rd_data == {8'h00, $past(wr_data[7:0], 2) & CPR_MASK})
    else $error("coprocessor route readback wrong");

  a_chan_readback: assert property (
    wr_stb && hit_cds ##1 rd_stb && hit_cds && !wr_stb |=>
      rd_data == {8'h00, $past(wr_data[7:0], 2) & CDS_MASK})
    else $error("channel drive readback wrong");

  // Reserved positions of the drive registers and the serial route upper byte never show a one
  a_resv_bds: assert property (
    rd_stb && hit_bds |=> (rd_data & 16'hffee) == 16'h0000)
    else $error("bus drive reserved bits nonzero");

  a_resv_cds: assert property (
    rd_stb && hit_cds |=> (rd_data & 16'hffaa) == 16'h0000)
    else $error("channel drive reserved bits nonzero");

  a_resv_spr: assert property (
    rd_stb && hit_spr |=> rd_data[15:8] == 8'h00)
    else $error("serial route upper byte nonzero");

  // Timer fields, pin 3 in the top pair
  a_tin_upper: assert property (
    wr_stb && hit_tpr |=> timer_input_fn[7:2] == $past(wr_data[15:10]))
    else $error("timer inputs 3 to 1 wrong");

  a_tin_pin0: assert property (
    wr_stb && hit_tpr |=> timer_input_fn[1:0] ==
      (($past(wr_data[9:8]) == 2'h1) ? 2'h0 : $past(wr_data[9:8])))
    else $error("timer input 0 wrong");

  a_tout_pin3: assert property (
    wr_stb && hit_tpr |=> timer_output_fn[7:6] == $past(wr_data[7:6]))
    else $error("timer output 3 wrong");

  a_tout_lower: assert property (
    wr_stb && hit_tpr && wr_data[5:4] != 2'h1 && wr_data[3:2] != 2'h1 &&
      wr_data[1:0] != 2'h1 |=> timer_output_fn[5:0] == $past(wr_data[5:0]))
    else $error("timer outputs 2 to 0 wrong");

  // Pins without a code 01 alternate never show it
  a_timer_no_alt: assert property (
    timer_output_fn[5:4] != 2'h1 && timer_output_fn[3:2] != 2'h1 &&
      timer_output_fn[1:0] != 2'h1 && timer_input_fn[1:0] != 2'h1)
    else $error("timer pin shows missing alternate");

  a_serial_no_alt: assert property (
    select1_route_field != 2'h1 && data_in_route_field != 2'h1 &&
      serial_clock_route_field != 2'h1)
    else $error("serial pin shows code 01");

  // Drive bits follow a write directly
  a_bus_main_drive: assert property (
    wr_stb && hit_bds |=> bus_main_drive_bit == $past(wr_data[4]))
    else $error("bus main drive wrong");

  a_bus_hs_drive: assert property (
    wr_stb && hit_bds |=> bus_handshake_drive_bit == $past(wr_data[0]))
    else $error("bus handshake drive wrong");

  // Levels hold between writes; late strap moves must not leak in
  a_serial_hold: assert property (
    !(wr_stb && hit_spr) |=> $stable({select1_route_field, select0_route_bit,
      data_in_route_field, data_out_route_bit, serial_clock_route_field}))
    else $error("serial route moved without write");

  a_timer_hold: assert property (
    !(wr_stb && hit_tpr) |=> $stable({timer_input_fn, timer_output_fn}))
    else $error("timer route moved without write");

  a_coproc_hold: assert property (
    !(wr_stb && hit_cpr) |=> $stable({time_base_clock_pin_fn,
      upper_channel_output_disable_fn, lower_channel_output_disable_fn}))
    else $error("coprocessor route moved without write");

  a_bus_drive_hold: assert property (
    !(wr_stb && hit_bds) |=> $stable({bus_main_drive_bit, bus_handshake_drive_bit}))
    else $error("bus drive moved without write");

  a_chan_drive_hold: assert property (
    !(wr_stb && hit_cds) |=> $stable(channel_drive_bits))
    else $error("channel drive moved without write");

  // Reset picture of the remaining outputs
  a_hs_strap_reset: assert property (
    $fell(rst) |-> bus_handshake_drive_bit == $past(strap_level))
    else $error("handshake strap reset wrong");

  a_config_forces_low: assert property (
    $fell(rst) && $past(rcfg_ok_reg) |-> !bus_main_drive_bit &&
      !bus_handshake_drive_bit && channel_drive_bits == 4'h0)
    else $error("config strap did not force low drive");

  a_route_default_all: assert property (
    $fell(rst) |-> !select0_route_bit && data_in_route_field == FN_GPIO &&
      !data_out_route_bit && serial_clock_route_field == FN_GPIO &&
      timer_output_fn == 8'h00 && !upper_channel_output_disable_fn &&
      !lower_channel_output_disable_fn && rd_data == 16'h0000)
    else $error("routes not all GPIO after reset");

  c_sdram_enable: cover property (wr_stb && hit_spr && wr_data[7:6] == 2'h2);
  c_timer_dma: cover property (wr_stb && hit_tpr && wr_data[9:8] == 2'h2);
  c_strap_high: cover property ($fell(rst) && bus_main_drive_bit);
  c_chan_read: cover property (rd_stb && hit_cds ##1 rd_data != 16'h0000);
  c_back_to_back: cover property (wr_stb && hit_tpr ##1 rd_stb && hit_tpr);

endmodule

// ===== test/tb_top.sv
// Self-checking bench for the pin routing and drive strength registers
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end

module tb_top
  import pfds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;
  logic        rst;
  logic [23:0] addr;
  logic [15:0] wr_data;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rd_data;
  logic        reset_config_pin;
  logic        strap_data21;
  logic [1:0]  sel1_f;
  logic        sel0_b;
  logic [1:0]  din_f;
  logic        dout_b;
  logic [1:0]  sck_f;
  logic [7:0]  tin_fn;
  logic [7:0]  tout_fn;
  logic        tb_fn;
  logic        ud_fn;
  logic        ld_fn;
  logic        main_drv;
  logic        hs_drv;
  logic [3:0]  ch_drv;
  int          miscompares;
  int          checks_done;
  logic [1:0]  cv;
  logic [7:0]  v;
  logic [1:0]  e2;

  pfds_pin_mux pfds_pin_mux_i (
    .sys_clk                         (sys_clk),
    .rst                             (rst),
    .addr                            (addr),
    .wr_data                         (wr_data),
    .wr_stb                          (wr_stb),
    .rd_stb                          (rd_stb),
    .rd_data                         (rd_data),
    .reset_config_pin                (reset_config_pin),
    .strap_data21                    (strap_data21),
    .select1_route_field             (sel1_f),
    .select0_route_bit               (sel0_b),
    .data_in_route_field             (din_f),
    .data_out_route_bit              (dout_b),
    .serial_clock_route_field        (sck_f),
    .timer_input_fn                  (tin_fn),
    .timer_output_fn                 (tout_fn),
    .time_base_clock_pin_fn          (tb_fn),
    .upper_channel_output_disable_fn (ud_fn),
    .lower_channel_output_disable_fn (ld_fn),
    .bus_main_drive_bit              (main_drv),
    .bus_handshake_drive_bit         (hs_drv),
    .channel_drive_bits              (ch_drv)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic final_report;
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge sys_clk);
    wr_stb  <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [23:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    `CHK("rd_data", e, rd_data);
  endtask

  // Write then read with no gap between the strobes
  task automatic wr_rd(input logic [23:0] a, input logic [15:0] d, input logic [15:0] e);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge sys_clk);
    wr_stb  <= 1'b0;
    rd_stb  <= 1'b1;
    @(posedge sys_clk);
    rd_stb  <= 1'b0;
    #1;
    `CHK("rd_data", e, rd_data);
  endtask

  task automatic do_reset(input logic cfg, input logic d21);
    reset_config_pin <= cfg;
    strap_data21     <= d21;
    rst              <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("sel1", 2'h0, sel1_f);
    `CHK("tin", 8'h00, tin_fn);
    `CHK("cpr", 3'h0, {tb_fn, ud_fn, ld_fn});
    `CHK("drive", {6{d21 & ~cfg}}, {main_drv, hs_drv, ch_drv});
  endtask

  // Hang guard
  initial begin
    #200000;
    miscompares++;
    final_report();
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    addr = 24'h000000;
    wr_data = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    reset_config_pin = 1'b0;
    strap_data21 = 1'b1;
    miscompares = 0;
    checks_done = 0;
    do_reset(1'b0, 1'b1);
    // Strap moves after reset must not reach the drive bits
    reset_config_pin <= 1'b1;
    strap_data21 <= 1'b0;
    rd(BDS_OFS, 16'h0011);
    rd(CDS_OFS, 16'h0055);
    rd(SPR_OFS, 16'h0000);
    rd(TPR_OFS, 16'h0000);
    rd(CPR_OFS, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      cv = c[1:0];
      v = {cv, cv[0], cv, cv[1], cv};
      e2 = cv[1] ? cv : 2'h0;
      wr(SPR_OFS, {8'h00, v});
      `CHK("sel1", e2, sel1_f);
      `CHK("sel0", cv[0], sel0_b);
      `CHK("din", e2, din_f);
      `CHK("dout", cv[1], dout_b);
      `CHK("sck", e2, sck_f);
      rd(SPR_OFS, {8'h00, v});
      wr(TPR_OFS, {8{cv}});
      `CHK("tin", (cv == 2'h1) ? 8'h54 : {4{cv}}, tin_fn);
      `CHK("tout", (cv == 2'h1) ? 8'h40 : {4{cv}}, tout_fn);
      rd(TPR_OFS, {8{cv}});
    end
    // Distinct codes per pin pin down field order
    wr(TPR_OFS, 16'h1be4);
    `CHK("tin", 8'h1b, tin_fn);
    `CHK("tout", 8'he0, tout_fn);
    wr(CPR_OFS, 16'h00fa);
    `CHK("cpr", 3'h2, {tb_fn, ud_fn, ld_fn});
    rd(CPR_OFS, 16'h0002);
    wr(CPR_OFS, 16'h0005);
    `CHK("cpr", 3'h5, {tb_fn, ud_fn, ld_fn});
    wr(BDS_OFS, 16'hffee);
    `CHK("bus", 2'h0, {main_drv, hs_drv});
    rd(BDS_OFS, 16'h0000);
    wr(BDS_OFS, 16'h0010);
    `CHK("bus", 2'h2, {main_drv, hs_drv});
    rd(BDS_OFS, 16'h0010);
    wr(BDS_OFS, 16'h0001);
    `CHK("bus", 2'h1, {main_drv, hs_drv});
    wr(CDS_OFS, 16'h00aa);
    `CHK("chan", 4'h0, ch_drv);
    rd(CDS_OFS, 16'h0000);
    wr(CDS_OFS, 16'h0014);
    `CHK("chan", 4'h6, ch_drv);
    rd(CDS_OFS, 16'h0014);
    // Unmapped places neither store nor answer
    wr(24'h100052, 16'hffff);
    rd(24'h100052, 16'h0000);
    rd(24'h10004b, 16'h0000);
    rd(CDS_OFS, 16'h0014);
    @(posedge sys_clk);
    #1;
    `CHK("rd_idle", 16'h0000, rd_data);
    wr_rd(SPR_OFS, 16'h00c0, 16'h00c0);
    `CHK("sel1", 2'h3, sel1_f);
    wr_rd(TPR_OFS, 16'hae27, 16'hae27);
    `CHK("tin", 8'hae, tin_fn);
    `CHK("tout", 8'h23, tout_fn);
    wr_rd(CPR_OFS, 16'hffff, 16'h0007);
    wr_rd(BDS_OFS, 16'h0011, 16'h0011);
    `CHK("bus", 2'h3, {main_drv, hs_drv});
    wr_rd(CDS_OFS, 16'hffff, 16'h0055);
    `CHK("chan", 4'hf, ch_drv);
    do_reset(1'b1, 1'b1);
    rd(BDS_OFS, 16'h0000);
    final_report();
  end
endmodule
